// File: logic/icw_cfg.svh
`ifndef ICW_CFG_SVH
`define ICW_CFG_SVH
`define ICW_CLK_NS 25
`define ICW_OFF_GCR 6'h02
`define ICW_OFF_QBASE 6'h10
`define ICW_OFF_HSIZE 6'h12
`define ICW_OFF_TX_MONITOR_IRQ_REG 6'h30
`define ICW_OFF_IR 6'h38
`define ICW_OFF_TIMER 6'h3a
`define ICW_OFF_ID_CONTROL_REG 6'h3c
`define ICW_OFF_WDCNT 6'h3e
`define ICW_GCR_CLOCK_PAIR_SELECT 0
`define ICW_GCR_FORCE 1
`define ICW_GCR_WDFS 2
`define ICW_ID_CONTROL_REG_WDR 0
`define ICW_ID_CONTROL_REG_TSEN 1
`define ICW_ID_CONTROL_REG_SWRST 2
`define ICW_IR_PEND 0
`define ICW_IR_TXMON 3
`define ICW_IR_OVF 4
`define ICW_IR_FIFO 7
`define ICW_GCR_RST 16'h0000
`define ICW_QBASE_RST 16'h0000
`define ICW_QSIZE_RST 16'h0100
`define ICW_HDLC_OFS 24'h00_0100
`define ICW_WD_STEP_US 250
`define ICW_WD_RST_MS 512
`define ICW_WD_MAX_S 15
`define ICW_WD_RST 16'(`ICW_WD_RST_MS * 1000 / `ICW_WD_STEP_US)
`define ICW_WD_MAX 16'(`ICW_WD_MAX_S * 1000000 / `ICW_WD_STEP_US)
`define ICW_LOSS_US 200
`define ICW_LOSS_CYC (`ICW_LOSS_US * 1000 / `ICW_CLK_NS)
`define ICW_REPEAT_HZ 4000
`define ICW_REPEAT_CYC (1000000000 / `ICW_REPEAT_HZ / `ICW_CLK_NS)
`define ICW_XTAL_KHZ 32768
`define ICW_XTAL_DIV 8192
`define ICW_TICK_CYC ((`ICW_XTAL_DIV * 1000 / `ICW_XTAL_KHZ) * 1000 / `ICW_CLK_NS)
`endif

// File: logic/icw_pkg.sv
package icw_pkg;
    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } icw_evt_t;
    typedef struct packed {
        logic valid;
        logic [23:0] addr;
        logic [15:0] data;
    } icw_mem_t;
    typedef enum logic [1:0] {
        ICW_IDLE,
        ICW_EVT,
        ICW_STAMP
    } icw_seq_t;
endpackage

// File: logic/icw_clk_sup.sv
`timescale 1ns/1ps
module icw_clk_sup #(
    parameter int LOSS_CYC = 8000,
    parameter int REPEAT_CYC = 10000
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // Synchronised pair clocks, bit 1 is pair B
    input wire logic [1:0] i_clk_s,
    // Software selection
    input wire logic i_force,
    input wire logic i_force_b,
    // Status
    output logic o_pair_b,
    output logic o_fail
);
    localparam int LW = $clog2(LOSS_CYC + 1);
    localparam int RW = $clog2(REPEAT_CYC + 1);
    logic [1:0] prev_r;
    logic cand_r;
    logic absent_r;
    logic [LW-1:0] loss_r;
    logic [RW-1:0] rep_r;
    wire cur = i_clk_s[cand_r];
    wire prv = prev_r[cand_r];
    wire fall = prv & ~cur;
    wire edge_c = prv ^ cur;
    wire chg = i_force && (cand_r != i_force_b);
    wire lost = !edge_c && (loss_r == LW'(LOSS_CYC - 1));
    wire rep = absent_r && (rep_r == RW'(REPEAT_CYC - 1));

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            prev_r <= 2'h0;
            cand_r <= 1'b0;
            absent_r <= 1'b0;
            loss_r <= '0;
            rep_r <= '0;
            o_pair_b <= 1'b0;
            o_fail <= 1'b0;
        end else begin
            prev_r <= i_clk_s;
            o_fail <= (lost && !chg && !absent_r) || rep;
            rep_r <= (!absent_r || rep) ? '0 : rep_r + 1'b1;
            if (chg) begin
                cand_r <= i_force_b;
                loss_r <= '0;
            end else if (edge_c) begin
                loss_r <= '0;
                if (fall) begin
                    o_pair_b <= cand_r;
                    absent_r <= 1'b0;
                end
            end else if (lost) begin
                loss_r <= '0;
                absent_r <= 1'b1;
                if (!i_force) begin
                    cand_r <= ~cand_r;
                end
            end else begin
                loss_r <= loss_r + 1'b1;
            end
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    a_loss_flagged: assert property ((lost && !chg && !absent_r) |=> (absent_r && o_fail))
        else $error("clock loss not flagged");
    a_fail_repeat: assert property (rep |=> o_fail)
        else $error("clock failure not repeated");
    a_switch_fall: assert property ($changed(o_pair_b) |-> $past(fall))
        else $error("pair switched off a falling edge");
endmodule

// File: logic/icw_wdog.sv
`timescale 1ns/1ps
`include "icw_cfg.svh"
module icw_wdog #(
    parameter int TICK_CYC = 10000
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // Control
    input wire logic i_clr,
    input wire logic i_fs_s,
    input wire logic i_src_fs,
    input wire logic i_ts_en,
    input wire logic i_restart,
    input wire logic [15:0] i_init,
    // Status
    output logic [15:0] o_count,
    output logic o_expired
);
    localparam int TW = $clog2(TICK_CYC + 1);
    logic [TW-1:0] div_r;
    logic fs_prev_r;
    logic half_r;
    wire xt_tick = div_r == TW'(TICK_CYC - 1);
    wire fs_rise = i_fs_s & ~fs_prev_r;
    wire tick = i_src_fs ? (fs_rise & half_r) : xt_tick;

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            div_r <= '0;
            fs_prev_r <= 1'b0;
            half_r <= 1'b0;
            o_count <= `ICW_WD_RST;
            o_expired <= 1'b0;
        end else begin
            fs_prev_r <= i_fs_s;
            div_r <= xt_tick ? '0 : div_r + 1'b1;
            if (fs_rise) begin
                half_r <= ~half_r;
            end
            if (i_clr) begin
                o_count <= `ICW_WD_RST;
                o_expired <= 1'b0;
            end else if (i_restart) begin
                o_count <= i_init;
                o_expired <= 1'b0;
            end else if (i_ts_en) begin
                o_expired <= 1'b0;
                if (tick) begin
                    o_count <= o_count + 16'h0001;
                end
            end else if (tick) begin
                if (o_count != 16'h0000) begin
                    o_count <= o_count - 16'h0001;
                end else begin
                    o_expired <= 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    a_wd_expire: assert property ((tick && o_count == 16'h0000 && !i_ts_en && !i_restart && !i_clr) |=> o_expired)
        else $error("watchdog did not expire");
    a_wd_restart: assert property ((i_restart && !i_clr) |=> (o_count == $past(i_init) && !o_expired))
        else $error("watchdog restart not loaded");
    a_ts_no_wd: assert property (i_ts_en |=> !o_expired)
        else $error("watchdog active during time stamping");
endmodule

// File: logic/icw_top.sv
`timescale 1ns/1ps
`include "icw_cfg.svh"
// Function
// - Route HDLC, C/I, monitor events to operating interrupt
// - Write cause to memory, then raise interrupt
// - Three queues: HDLC, command/indicate, monitor
// - Overflow and FIFO errors flag source register
// - 16-bit register names interrupting monitor transmitter
// - Clock fault raises time-base interrupt
// - Missing clock detected within 200 microseconds
// - Clock failure interrupt repeats at 4 kHz
// - Hunt pairs; switch on new falling edge
// - Software may force clock pair choice
// - Queue lengths set by software
// - Time stamp word follows C/I, monitor entries
// - Time stamping disables the watchdog
// - Watchdog counts down; expiry raises output
// - Initial value 0 to 15 s, 0.25 ms
// - Reset loads 512 ms into watchdog
// - Count clock: frame sync/2 or crystal/8192
// - Crystal source selected after reset
// - Any reset restores register defaults
module icw_top #(
    parameter int LOSS_CYC = `ICW_LOSS_CYC,
    parameter int REPEAT_CYC = `ICW_REPEAT_CYC,
    parameter int TICK_CYC = `ICW_TICK_CYC
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // Clock distribution and frame sync pins
    input wire logic i_clk_a,
    input wire logic i_clk_b,
    input wire logic i_frame_sync,
    // Register port
    input wire logic [5:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    // Event sources: 0 HDLC, 1 monitor, 2 C/I
    input wire icw_pkg::icw_evt_t [2:0] i_evt,
    output logic [2:0] o_evt_ready,
    input wire logic i_txmon_valid,
    input wire logic [3:0] i_txmon_idx,
    input wire logic i_fifo_err,
    // Queue memory writes
    output icw_pkg::icw_mem_t o_mem,
    input wire logic i_mem_ack,
    // Interrupt and status outputs
    output logic o_operating_irq_out,
    output logic o_timebase_irq_out,
    output logic o_watchdog_out,
    output logic o_clock_pair_b
);
    function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
        return a == off;
    endfunction

    // Pin synchronisers
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
        end else begin
            pin_s1_r <= {i_frame_sync, i_clk_b, i_clk_a};
            pin_s2_r <= pin_s1_r;
        end
    end

    // Register decode
    wire wr_gcr = i_reg_wr && hit(i_reg_addr, `ICW_OFF_GCR);
    wire wr_qbase = i_reg_wr && hit(i_reg_addr, `ICW_OFF_QBASE);
    wire wr_timer = i_reg_wr && hit(i_reg_addr, `ICW_OFF_TIMER);
    wire wr_id_control_reg = i_reg_wr && hit(i_reg_addr, `ICW_OFF_ID_CONTROL_REG);
    wire rd_ir = i_reg_rd && hit(i_reg_addr, `ICW_OFF_IR);
    wire rd_tx_monitor_irq_reg = i_reg_rd && hit(i_reg_addr, `ICW_OFF_TX_MONITOR_IRQ_REG);

    logic [15:0] gcr_r;
    logic [15:0] qbase_r;
    logic [15:0] timer_r;
    logic [2:0][15:0] qsize_r;
    logic [2:0][15:0] qsize_nxt;
    logic ts_en_r;
    logic restart_r;
    logic soft_rst_r;
    wire clr = soft_rst_r;

    // Next values of programmable registers
    wire [15:0] gcr_nxt = clr ? `ICW_GCR_RST : wr_gcr ? i_reg_wdata : gcr_r;
    wire [15:0] qbase_nxt = clr ? `ICW_QBASE_RST : wr_qbase ? i_reg_wdata : qbase_r;
    wire [15:0] wd_lim = (i_reg_wdata > `ICW_WD_MAX) ? `ICW_WD_MAX : i_reg_wdata;
    wire [15:0] timer_nxt = clr ? `ICW_WD_RST : wr_timer ? wd_lim : timer_r;
    wire ts_en_nxt = clr ? 1'b0 : wr_id_control_reg ? i_reg_wdata[`ICW_ID_CONTROL_REG_TSEN] : ts_en_r;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_size
            wire wr_sz = i_reg_wr && hit(i_reg_addr, `ICW_OFF_HSIZE + 6'(g));
            assign qsize_nxt[g] = clr ? `ICW_QSIZE_RST : wr_sz ? i_reg_wdata : qsize_r[g];
        end
    endgenerate

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            gcr_r <= `ICW_GCR_RST;
            qbase_r <= `ICW_QBASE_RST;
            timer_r <= `ICW_WD_RST;
            qsize_r <= {3{`ICW_QSIZE_RST}};
            ts_en_r <= 1'b0;
            restart_r <= 1'b0;
            soft_rst_r <= 1'b0;
        end else begin
            gcr_r <= gcr_nxt;
            qbase_r <= qbase_nxt;
            timer_r <= timer_nxt;
            qsize_r <= qsize_nxt;
            ts_en_r <= ts_en_nxt;
            restart_r <= wr_id_control_reg && i_reg_wdata[`ICW_ID_CONTROL_REG_WDR];
            soft_rst_r <= wr_id_control_reg && i_reg_wdata[`ICW_ID_CONTROL_REG_SWRST];
        end
    end

    // Queue sequencer state
    icw_pkg::icw_seq_t seq_r;
    logic [1:0] cur_q_r;
    icw_pkg::icw_mem_t mem_r;
    logic [2:0] empty_r;
    logic [2:0][15:0] word_r;
    logic [2:0][15:0] wptr_r;
    logic [2:0][15:0] fill_r;
    logic [2:0][23:0] qstart;
    logic [2:0] fin;
    logic [2:0] ovf;
    logic [15:0] wd_count;

    wire need_stamp = ts_en_r && (cur_q_r != 2'h0);
    wire in_evt = seq_r == icw_pkg::ICW_EVT;
    wire in_stamp = seq_r == icw_pkg::ICW_STAMP;
    wire ack_evt = in_evt && i_mem_ack;
    wire done = i_mem_ack && ((in_evt && !need_stamp) || in_stamp);
    wire any = ~&empty_r;
    wire [1:0] sel_q = !empty_r[0] ? 2'h0 : !empty_r[1] ? 2'h1 : 2'h2;

    assign qstart[0] = {qbase_r, 8'h00} + `ICW_HDLC_OFS;

    generate
        for (g = 0; g < 3; g++) begin : g_queue
            wire take = i_evt[g].valid && empty_r[g];
            wire [15:0] esz = (ts_en_r && g != 0) ? 16'h0002 : 16'h0001;
            wire [15:0] wnext = wptr_r[g] + esz;
            wire [15:0] fsum = fill_r[g] + esz;
            assign fin[g] = done && (cur_q_r == 2'(g));
            assign ovf[g] = fin[g] && (fsum > qsize_r[g]);
            if (g > 0) begin : g_start
                assign qstart[g] = qstart[g-1] + {8'h00, qsize_r[g-1]};
            end
            always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    empty_r[g] <= 1'b1;
                    word_r[g] <= 16'h0000;
                    wptr_r[g] <= 16'h0000;
                    fill_r[g] <= 16'h0000;
                end else if (clr) begin
                    empty_r[g] <= 1'b1;
                    wptr_r[g] <= 16'h0000;
                    fill_r[g] <= 16'h0000;
                end else begin
                    if (take) begin
                        empty_r[g] <= 1'b0;
                        word_r[g] <= i_evt[g].word;
                    end else if (ack_evt && cur_q_r == 2'(g)) begin
                        empty_r[g] <= 1'b1;
                    end
                    if (fin[g]) begin
                        wptr_r[g] <= (wnext >= qsize_r[g]) ? 16'h0000 : wnext;
                    end
                    if (rd_ir) begin
                        fill_r[g] <= fin[g] ? esz : 16'h0000;
                    end else if (fin[g]) begin
                        fill_r[g] <= fsum;
                    end
                end
            end
        end
    endgenerate

    wire [23:0] ent_addr = qstart[sel_q] + {8'h00, wptr_r[sel_q]};

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            seq_r <= icw_pkg::ICW_IDLE;
            cur_q_r <= 2'h0;
            mem_r <= '0;
        end else begin
            unique case (seq_r)
                icw_pkg::ICW_IDLE: begin
                    if (any && !clr) begin
                        cur_q_r <= sel_q;
                        mem_r <= '{valid: 1'b1, addr: ent_addr, data: word_r[sel_q]};
                        seq_r <= icw_pkg::ICW_EVT;
                    end
                end
                icw_pkg::ICW_EVT: begin
                    if (i_mem_ack) begin
                        if (need_stamp) begin
                            mem_r.addr <= mem_r.addr + 24'h00_0001;
                            mem_r.data <= wd_count;
                            seq_r <= icw_pkg::ICW_STAMP;
                        end else begin
                            mem_r.valid <= 1'b0;
                            seq_r <= icw_pkg::ICW_IDLE;
                        end
                    end
                end
                icw_pkg::ICW_STAMP: begin
                    if (i_mem_ack) begin
                        mem_r.valid <= 1'b0;
                        seq_r <= icw_pkg::ICW_IDLE;
                    end
                end
            endcase
        end
    end

    // Interrupt source and transmit monitor registers
    logic [7:0] ir_r;
    logic [15:0] tx_monitor_irq_reg_r;
    logic operating_irq_out_r;
    logic [15:0] rdata_r;
    logic [7:0] ir_set;
    assign ir_set[`ICW_IR_PEND +: 3] = fin;
    assign ir_set[`ICW_IR_TXMON] = i_txmon_valid;
    assign ir_set[`ICW_IR_OVF +: 3] = ovf;
    assign ir_set[`ICW_IR_FIFO] = i_fifo_err;
    wire [7:0] ir_keep = (clr || rd_ir) ? 8'h00 : ir_r;
    wire [7:0] ir_nxt = ir_keep | ir_set;
    wire [15:0] tm_set = i_txmon_valid ? (16'h0001 << i_txmon_idx) : 16'h0000;
    wire [15:0] tm_keep = (clr || rd_tx_monitor_irq_reg) ? 16'h0000 : tx_monitor_irq_reg_r;
    wire [15:0] tx_monitor_irq_reg_nxt = tm_keep | tm_set;

    wire [15:0] rd_mux =
        hit(i_reg_addr, `ICW_OFF_GCR) ? gcr_r :
        hit(i_reg_addr, `ICW_OFF_TX_MONITOR_IRQ_REG) ? tx_monitor_irq_reg_r :
        hit(i_reg_addr, `ICW_OFF_IR) ? {8'h00, ir_r} :
        hit(i_reg_addr, `ICW_OFF_QBASE) ? qbase_r :
        hit(i_reg_addr, `ICW_OFF_HSIZE) ? qsize_r[0] :
        hit(i_reg_addr, `ICW_OFF_HSIZE + 6'h01) ? qsize_r[1] :
        hit(i_reg_addr, `ICW_OFF_HSIZE + 6'h02) ? qsize_r[2] :
        hit(i_reg_addr, `ICW_OFF_TIMER) ? timer_r :
        hit(i_reg_addr, `ICW_OFF_ID_CONTROL_REG) ? {14'h0000, ts_en_r, 1'b0} :
        hit(i_reg_addr, `ICW_OFF_WDCNT) ? wd_count :
        16'h0000;

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ir_r <= 8'h00;
            tx_monitor_irq_reg_r <= 16'h0000;
            operating_irq_out_r <= 1'b0;
            rdata_r <= 16'h0000;
        end else begin
            ir_r <= ir_nxt;
            tx_monitor_irq_reg_r <= tx_monitor_irq_reg_nxt;
            operating_irq_out_r <= |ir_nxt;
            if (i_reg_rd) begin
                rdata_r <= rd_mux;
            end
        end
    end

    logic tb_fail;
    logic pair_b;
    logic wd_exp;

    icw_clk_sup #(
        .LOSS_CYC(LOSS_CYC),
        .REPEAT_CYC(REPEAT_CYC)
    ) u_sup (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_s(pin_s2_r[1:0]),
        .i_force(gcr_r[`ICW_GCR_FORCE]),
        .i_force_b(gcr_r[`ICW_GCR_CLOCK_PAIR_SELECT]),
        .o_pair_b(pair_b),
        .o_fail(tb_fail)
    );

    icw_wdog #(
        .TICK_CYC(TICK_CYC)
    ) u_wdog (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_clr(clr),
        .i_fs_s(pin_s2_r[2]),
        .i_src_fs(gcr_r[`ICW_GCR_WDFS]),
        .i_ts_en(ts_en_r),
        .i_restart(restart_r),
        .i_init(timer_r),
        .o_count(wd_count),
        .o_expired(wd_exp)
    );

    assign o_reg_rdata = rdata_r;
    assign o_evt_ready = empty_r;
    assign o_mem = mem_r;
    assign o_operating_irq_out = operating_irq_out_r;
    assign o_timebase_irq_out = tb_fail;
    assign o_watchdog_out = wd_exp;
    assign o_clock_pair_b = pair_b;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_evt_to_stamp;
        in_evt && i_mem_ack && need_stamp;
    endsequence
    sequence s_quiet_read;
        rd_ir && (ir_set == 8'h00) && !clr;
    endsequence
    a_stamp_next: assert property (s_evt_to_stamp |=> (in_stamp && o_mem.valid && o_mem.data == $past(wd_count)))
        else $error("time stamp word not written");
    a_write_first: assert property ($rose(ir_r[0]) |-> $past(i_mem_ack && cur_q_r == 2'h0))
        else $error("pending bit before memory write");
    a_fifo_flag: assert property ((i_fifo_err && !clr) |=> (ir_r[`ICW_IR_FIFO] && o_operating_irq_out))
        else $error("fifo error not flagged");
    a_read_clear: assert property (s_quiet_read |=> !o_operating_irq_out)
        else $error("interrupt held after read");
    a_hdlc_start: assert property ((seq_r == icw_pkg::ICW_IDLE && any && !clr && sel_q == 2'h0 &&
        wptr_r[0] == 16'h0000) |=> (o_mem.addr == $past(qstart[0])))
        else $error("hdlc queue start wrong");
    a_txmon_bit: assert property ((i_txmon_valid && !clr) |=> tx_monitor_irq_reg_r[$past(i_txmon_idx)])
        else $error("monitor transmitter bit missing");
endmodule

// File: bench/icw_host_model.sv
`timescale 1ns/1ps
module icw_host_model (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // Queue writes from the device
    input wire icw_pkg::icw_mem_t i_mem,
    input wire logic i_slow,
    output logic o_mem_ack,
    // Captured queue entries
    output logic [23:0] o_last_addr,
    output logic [23:0] o_prev_addr,
    output logic [15:0] o_last_data,
    output logic [7:0] o_count
);
    logic [1:0] wait_r;
    // Shared memory answering queue writes, prompt or after three cycles
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_mem_ack <= 1'b0;
            wait_r <= 2'h0;
            o_last_addr <= 24'h00_0000;
            o_prev_addr <= 24'h00_0000;
            o_last_data <= 16'h0000;
            o_count <= 8'h00;
        end else if (o_mem_ack) begin
            o_mem_ack <= 1'b0;
        end else if (i_mem.valid && (!i_slow || wait_r == 2'h3)) begin
            o_mem_ack <= 1'b1;
            wait_r <= 2'h0;
            o_prev_addr <= o_last_addr;
            o_last_addr <= i_mem.addr;
            o_last_data <= i_mem.data;
            o_count <= o_count + 8'h01;
        end else if (i_mem.valid) begin
            wait_r <= wait_r + 2'h1;
        end
    end
endmodule

// File: bench/test_icw_top.sv
`timescale 1ns/1ps
module test_icw_top;
    typedef struct packed {logic [5:0] addr; logic [15:0] exp;} icw_row_t;
    localparam icw_row_t ROWS [9] = '{'{6'h02, 16'h0000}, '{6'h10, 16'h0000}, '{6'h12, 16'h0100},
        '{6'h13, 16'h0100}, '{6'h14, 16'h0100}, '{6'h30, 16'h0000}, '{6'h38, 16'h0000},
        '{6'h3a, 16'h0800}, '{6'h20, 16'h0000}};
    logic i_sys_clk, i_sys_rst, i_clk_a, i_clk_b, run_a, run_b, i_reg_wr, i_reg_rd, slow;
    logic i_txmon_valid, i_fifo_err, i_mem_ack, o_operating_irq_out, o_timebase_irq_out;
    logic o_watchdog_out, o_clock_pair_b, run_fs, i_frame_sync;
    logic [5:0] i_reg_addr;
    logic [15:0] i_reg_wdata, o_reg_rdata, last_data;
    logic [3:0] i_txmon_idx;
    logic [2:0] o_evt_ready;
    logic [23:0] last_addr, prev_addr;
    logic [7:0] mem_count;
    icw_pkg::icw_evt_t [2:0] i_evt;
    icw_pkg::icw_mem_t o_mem;
    int mismatches, n_tests, cycles, tb_cnt, k;

    icw_top #(.LOSS_CYC(20), .REPEAT_CYC(40), .TICK_CYC(16)) icw_top_inst (.i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst), .i_clk_a(i_clk_a), .i_clk_b(i_clk_b), .i_frame_sync(i_frame_sync),
        .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .i_evt(i_evt), .o_evt_ready(o_evt_ready), .i_txmon_valid(i_txmon_valid),
        .i_txmon_idx(i_txmon_idx), .i_fifo_err(i_fifo_err), .o_mem(o_mem), .i_mem_ack(i_mem_ack),
        .o_operating_irq_out(o_operating_irq_out), .o_timebase_irq_out(o_timebase_irq_out),
        .o_watchdog_out(o_watchdog_out), .o_clock_pair_b(o_clock_pair_b));
    icw_host_model icw_host_model_inst (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_mem(o_mem),
        .i_slow(slow), .o_mem_ack(i_mem_ack), .o_last_addr(last_addr), .o_prev_addr(prev_addr),
        .o_last_data(last_data), .o_count(mem_count));

    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    // Pair clocks, standing still when stopped
    always @(posedge i_sys_clk) begin
        if (run_a) i_clk_a <= ~i_clk_a;
        if (run_b) i_clk_b <= ~i_clk_b;
        if (run_fs) i_frame_sync <= ~i_frame_sync;
        if (o_timebase_irq_out === 1'b1) tb_cnt++;
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            test_done();
        end
    end

    task test_done;
        if (mismatches == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task check(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask
    task wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_wr <= 1'b0;
    endtask
    task rd_chk(input logic [5:0] a, input logic [15:0] exp);
        @(posedge i_sys_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_rd <= 1'b0;
        #1;
        check(o_reg_rdata, exp);
    endtask
    task evt(input int q, input logic [15:0] w);
        @(posedge i_sys_clk);
        i_evt[q].valid <= 1'b1;
        i_evt[q].word <= w;
        k = 0;
        do begin
            @(posedge i_sys_clk);
            k++;
        end while (o_evt_ready[q] !== 1'b1 && k < 100);
        i_evt[q].valid <= 1'b0;
    endtask
    task wait_mem(input logic [7:0] n);
        k = 0;
        while (mem_count !== n && k < 200) begin
            @(posedge i_sys_clk);
            k++;
        end
        check(mem_count, n);
    endtask

    initial begin
        {mismatches, n_tests, cycles, tb_cnt} = '0;
        {i_sys_rst, run_a, i_clk_a, i_clk_b} = 4'hc;
        {run_b, run_fs, i_frame_sync, i_reg_wr, i_reg_rd, slow, i_txmon_valid, i_fifo_err} = '0;
        {i_reg_addr, i_reg_wdata, i_txmon_idx, i_evt} = '0;
        cyc(12);
        i_sys_rst <= 1'b0;
        foreach (ROWS[i]) rd_chk(ROWS[i].addr, ROWS[i].exp);
        check(o_evt_ready, 24'h00_0007);
        cyc(50);
        check(o_clock_pair_b, 24'h00_0000);
        check(tb_cnt != 0, 24'h00_0000);
        run_a <= 1'b0;
        run_b <= 1'b1;
        tb_cnt = 0;
        cyc(200);
        check(o_clock_pair_b, 24'h00_0001);
        check(tb_cnt != 0, 24'h00_0001);
        run_b <= 1'b0;
        tb_cnt = 0;
        cyc(150);
        check(tb_cnt >= 3, 24'h00_0001);
        wr(6'h02, 16'h0002);
        run_a <= 1'b1;
        cyc(100);
        check(o_clock_pair_b, 24'h00_0000);
        rd_chk(6'h02, 16'h0002);
        wr(6'h3a, 16'h0003);
        wr(6'h3c, 16'h0001);
        cyc(30);
        check(o_watchdog_out, 24'h00_0000);
        cyc(70);
        check(o_watchdog_out, 24'h00_0001);
        wr(6'h3c, 16'h0001);
        cyc(4);
        check(o_watchdog_out, 24'h00_0000);
        wr(6'h02, 16'h0006);
        wr(6'h3c, 16'h0001);
        cyc(100);
        check(o_watchdog_out, 24'h00_0000);
        run_fs <= 1'b1;
        cyc(30);
        check(o_watchdog_out, 24'h00_0001);
        run_fs <= 1'b0;
        wr(6'h02, 16'h0002);
        wr(6'h3c, 16'h0003);
        cyc(100);
        check(o_watchdog_out, 24'h00_0000);
        wr(6'h12, 16'h0004);
        for (int i = 0; i < 5; i++) evt(0, 16'h1230 + 16'(i));
        wait_mem(8'h05);
        check(last_addr, 24'h00_0100);
        check(prev_addr, 24'h00_0103);
        check(last_data, 16'h1234);
        cyc(3);
        check(o_operating_irq_out, 24'h00_0001);
        rd_chk(6'h38, 16'h0011);
        cyc(1);
        check(o_operating_irq_out, 24'h00_0000);
        slow <= 1'b1;
        evt(1, 16'h00a5);
        evt(2, 16'h00c3);
        wait_mem(8'h09);
        check(prev_addr, 24'h00_0204);
        check(last_addr, 24'h00_0205);
        check(o_evt_ready, 24'h00_0007);
        cyc(3);
        rd_chk(6'h38, 16'h0006);
        @(posedge i_sys_clk);
        {i_txmon_valid, i_fifo_err, i_txmon_idx} <= 6'h35;
        @(posedge i_sys_clk);
        {i_txmon_valid, i_fifo_err} <= 2'h0;
        cyc(3);
        rd_chk(6'h30, 16'h0020);
        rd_chk(6'h38, 16'h0088);
        wr(6'h3a, 16'hffff);
        rd_chk(6'h3a, 16'hea60);
        wr(6'h3c, 16'h0004);
        cyc(2);
        rd_chk(6'h02, 16'h0000);
        rd_chk(6'h12, 16'h0100);
        rd_chk(6'h3a, 16'h0800);
        check(o_evt_ready, 24'h00_0007);
        test_done();
    end
endmodule
